// ---- src/eor_defines.svh ----
`ifndef EOR_DEFINES_SVH
`define EOR_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define EOR_OFS_CTRL 8'h00
`define EOR_OFS_CFG_RECORD_END 8'h04
`define EOR_OFS_CFG_SAMPLES_FLOWING 8'h08
`define EOR_OFS_CFG_WAVEFORM_TAG 8'h0c
`define EOR_OFS_DELAY 8'h10
`define EOR_OFS_STATUS 8'h14

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define EOR_CTRL_GEN_BIT 0
`define EOR_F_DEST 0
`define EOR_F_POL 8
`define EOR_F_POS 16
`define EOR_F_TERM 24
`define EOR_CFG_MASK 32'h7f7f_7f1f
`define EOR_ST_FRONT 0
`define EOR_ST_CHASSIS 4
`define EOR_ST_SYNC 11
`define EOR_ST_VARIANT 24
`define EOR_ST_LVDS 25

// ------------------------------------------------------------
// selection codes
// ------------------------------------------------------------
`define EOR_POL_HIGH 7'h0a
`define EOR_POL_LOW 7'h0b
`define EOR_POS_RISE 7'h12
`define EOR_POS_FALL 7'h13
`define EOR_POS_DELAY 7'h14
`define EOR_TERM_LVDS 7'h40
`define EOR_TERM_SE 7'h41

// ------------------------------------------------------------
// destination codes
// ------------------------------------------------------------
`define EOR_DEST_NONE 5'h00
`define EOR_DEST_FRONT0 5'h01
`define EOR_DEST_CHASSIS0 5'h05
`define EOR_DEST_SYNC0 5'h0c
`define EOR_NUM_FRONT 4
`define EOR_NUM_BUS 7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define EOR_RST_CTRL 32'h0000_0000
`define EOR_RST_CFG 32'h4112_0a00
`define EOR_RST_DELAY 32'h0000_0000

`endif

// ---- src/eor_event_output_router.sv ----
// The Wishbone interface to the registers and the register addresses were decided locally.
`include "eor_defines.svh"
`default_nettype none

module eor_event_output_router import eor_pkg::*; #(
    parameter bit CHASSIS_VARIANT = 1'b1,
    parameter bit LVDS_CAPABLE = 1'b1,
    parameter int DELAY_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // internal events
    input wire logic record_end_event,
    input wire logic samples_flowing_event,
    input wire logic waveform_tag_event,
    // output terminals
    output logic [3:0] front_line,
    output logic [3:0] front_line_lvds,
    output logic [6:0] chassis_trigger_line,
    output logic [6:0] board_sync_line
);
    localparam int NEV = 3;

    if (DELAY_W < 1 || DELAY_W > 16) begin : g_bad_delay_w
        $error("DELAY_W must lie between 1 and 16");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic in_range(input logic [4:0] d, input logic [4:0] base, input int n);
        return (d >= base) && (d < 5'(base + n));
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] cfg_r [NEV];
    logic [DELAY_W-1:0] delay_r;
    logic gen_mode;
    logic bus_req;
    logic wr_en;
    logic [31:0] rd_nxt;

    assign gen_mode = ctrl_r[`EOR_CTRL_GEN_BIT];
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = bus_req & wb_we_i;

    // ack follows the request by one cycle and drops the next
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_r <= `EOR_RST_CTRL;
        end else if (wr_en && wb_adr_i == `EOR_OFS_CTRL) begin
            ctrl_r <= merge_sel(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int e = 0; e < NEV; e++) begin
                cfg_r[e] <= `EOR_RST_CFG;
            end
        end else if (wr_en) begin
            for (int e = 0; e < NEV; e++) begin
                if (wb_adr_i == 8'(`EOR_OFS_CFG_RECORD_END + 4 * e)) begin
                    cfg_r[e] <= merge_sel(cfg_r[e], wb_dat_i, wb_sel_i) & `EOR_CFG_MASK;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            delay_r <= DELAY_W'(`EOR_RST_DELAY);
        end else if (wr_en && wb_adr_i == `EOR_OFS_DELAY) begin
            delay_r <= DELAY_W'(merge_sel(32'(delay_r), wb_dat_i, wb_sel_i));
        end
    end

    // unmapped offsets read zero and ignore writes
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (wb_adr_i)
            `EOR_OFS_CTRL: rd_nxt = ctrl_r;
            `EOR_OFS_CFG_RECORD_END: rd_nxt = cfg_r[EOR_EV_RECORD_END];
            `EOR_OFS_CFG_SAMPLES_FLOWING: rd_nxt = cfg_r[EOR_EV_SAMPLES_FLOWING];
            `EOR_OFS_CFG_WAVEFORM_TAG: rd_nxt = cfg_r[EOR_EV_WAVEFORM_TAG];
            `EOR_OFS_DELAY: rd_nxt = 32'(delay_r);
            `EOR_OFS_STATUS: begin
                rd_nxt[`EOR_ST_FRONT +: 4] = front_line;
                rd_nxt[`EOR_ST_CHASSIS +: 7] = chassis_trigger_line;
                rd_nxt[`EOR_ST_SYNC +: 7] = board_sync_line;
                rd_nxt[`EOR_ST_VARIANT] = CHASSIS_VARIANT;
                rd_nxt[`EOR_ST_LVDS] = LVDS_CAPABLE;
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // effective selections
    // ------------------------------------------------------------
    logic [4:0] dest_eff [NEV];
    logic pol_low [NEV];
    eor_pos_t pos_eff [NEV];
    logic lvds_eff [NEV];

    always_comb begin
        logic [4:0] d;
        logic is_front;
        logic is_ch;
        logic is_sy;
        logic ok;
        logic gen_ok;
        logic [6:0] pos_code;
        d = '0;
        is_front = 1'b0;
        is_ch = 1'b0;
        is_sy = 1'b0;
        ok = 1'b0;
        gen_ok = 1'b0;
        pos_code = '0;
        for (int e = 0; e < NEV; e++) begin
            d = cfg_r[e][`EOR_F_DEST +: 5];
            is_front = in_range(d, `EOR_DEST_FRONT0, `EOR_NUM_FRONT);
            is_ch = in_range(d, `EOR_DEST_CHASSIS0, `EOR_NUM_BUS);
            is_sy = in_range(d, `EOR_DEST_SYNC0, `EOR_NUM_BUS);
            ok = is_front | (is_ch & CHASSIS_VARIANT) | (is_sy & ~CHASSIS_VARIANT);
            if (e == EOR_EV_SAMPLES_FLOWING) begin
                ok = ok & is_front & gen_mode;
            end
            dest_eff[e] = ok ? d : `EOR_DEST_NONE;
            gen_ok = (e != EOR_EV_WAVEFORM_TAG) || gen_mode;
            pol_low[e] = gen_ok && cfg_r[e][`EOR_F_POL +: 7] == `EOR_POL_LOW;
            pos_code = cfg_r[e][`EOR_F_POS +: 7];
            pos_eff[e] = EOR_POS_RISE_E;
            if (ok && is_front && gen_ok && e != EOR_EV_RECORD_END) begin
                if (pos_code == `EOR_POS_FALL) begin
                    pos_eff[e] = EOR_POS_FALL_E;
                end else if (pos_code == `EOR_POS_DELAY) begin
                    pos_eff[e] = EOR_POS_DELAY_E;
                end
            end
            // unsupported code falls back to single-ended
            lvds_eff[e] = ok && is_front && LVDS_CAPABLE &&
                          cfg_r[e][`EOR_F_TERM +: 7] == `EOR_TERM_LVDS;
        end
    end

    // ------------------------------------------------------------
    // pulse shaping
    // ------------------------------------------------------------
    logic ev_in [NEV];
    logic pulse [NEV];

    assign ev_in[EOR_EV_RECORD_END] = record_end_event;
    assign ev_in[EOR_EV_SAMPLES_FLOWING] = samples_flowing_event;
    assign ev_in[EOR_EV_WAVEFORM_TAG] = waveform_tag_event;

    for (genvar g = 0; g < NEV; g++) begin : g_shaper
        eor_event_shaper #(
            .DELAY_W(DELAY_W)
        ) u_shaper (
            .mclk(mclk),
            .rst_b(rst_b),
            .event_in(ev_in[g]),
            .pos_sel(pos_eff[g]),
            .delay_cyc(delay_r),
            .pulse_r(pulse[g])
        );
    end

    // ------------------------------------------------------------
    // line routing
    // ------------------------------------------------------------
    // two events on one line: the lower-numbered event owns it
    logic [3:0] front_nxt;
    logic [3:0] fall_sel_nxt;
    logic [3:0] lvds_nxt;
    logic [6:0] chassis_nxt;
    logic [6:0] sync_nxt;

    always_comb begin
        front_nxt = '0;
        fall_sel_nxt = '0;
        lvds_nxt = '0;
        chassis_nxt = '0;
        sync_nxt = '0;
        for (int e = NEV - 1; e >= 0; e--) begin
            for (int i = 0; i < `EOR_NUM_FRONT; i++) begin
                if (dest_eff[e] == 5'(`EOR_DEST_FRONT0 + i)) begin
                    front_nxt[i] = pulse[e] ^ pol_low[e];
                    fall_sel_nxt[i] = pos_eff[e] == EOR_POS_FALL_E;
                    lvds_nxt[i] = lvds_eff[e];
                end
            end
            for (int i = 0; i < `EOR_NUM_BUS; i++) begin
                if (dest_eff[e] == 5'(`EOR_DEST_CHASSIS0 + i)) begin
                    chassis_nxt[i] = pulse[e] ^ pol_low[e];
                end
                if (dest_eff[e] == 5'(`EOR_DEST_SYNC0 + i)) begin
                    sync_nxt[i] = pulse[e] ^ pol_low[e];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    logic [3:0] front_rise_r;
    logic [3:0] front_fall_r;
    logic [3:0] fall_sel_r;

    // unrouted lines settle low, the inactive level
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            front_rise_r <= '0;
            fall_sel_r <= '0;
            front_line_lvds <= '0;
            chassis_trigger_line <= '0;
            board_sync_line <= '0;
        end else begin
            front_rise_r <= front_nxt;
            fall_sel_r <= fall_sel_nxt;
            front_line_lvds <= lvds_nxt;
            chassis_trigger_line <= chassis_nxt;
            board_sync_line <= sync_nxt;
        end
    end

    // half-cycle retime; select is static so the mux does not glitch
    always_ff @(negedge mclk) begin
        if (!rst_b) begin
            front_fall_r <= '0;
        end else begin
            front_fall_r <= front_rise_r;
        end
    end

    always_comb begin
        for (int i = 0; i < `EOR_NUM_FRONT; i++) begin
            front_line[i] = fall_sel_r[i] ? front_fall_r[i] : front_rise_r[i];
        end
    end
endmodule // eor_event_output_router

`default_nettype wire

// ---- src/eor_event_shaper.sv ----
`default_nettype none

module eor_event_shaper import eor_pkg::*; #(
    parameter int DELAY_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // event and timing selection
    input wire logic event_in,
    input wire eor_pos_t pos_sel,
    input wire logic [DELAY_W-1:0] delay_cyc,
    // shaped pulse
    output logic pulse_r
);
    logic event_d_r;
    logic [DELAY_W-1:0] cnt_r;
    eor_dly_state_t state_r;
    logic rise;

    assign rise = event_in & ~event_d_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            event_d_r <= 1'b0;
        end else begin
            event_d_r <= event_in;
        end
    end

    // ------------------------------------------------------------
    // delayed launch
    // ------------------------------------------------------------
    // one pulse in flight; an edge while counting is dropped
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= EOR_DLY_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                EOR_DLY_IDLE: begin
                    if (rise && pos_sel == EOR_POS_DELAY_E) begin
                        state_r <= EOR_DLY_COUNT;
                        cnt_r <= delay_cyc;
                    end
                end
                EOR_DLY_COUNT: begin
                    if (cnt_r == '0) begin
                        state_r <= EOR_DLY_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= EOR_DLY_IDLE;
                end
            endcase
        end
    end

    // one clock wide whatever the event's own length
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= (rise && pos_sel != EOR_POS_DELAY_E) ||
                       (state_r == EOR_DLY_COUNT && cnt_r == '0);
        end
    end
endmodule // eor_event_shaper

`default_nettype wire

// ---- src/eor_pkg.sv ----
`default_nettype none

package eor_pkg;
    typedef enum logic [1:0] {
        EOR_POS_RISE_E = 2'h0,
        EOR_POS_FALL_E = 2'h1,
        EOR_POS_DELAY_E = 2'h3
    } eor_pos_t;

    typedef enum logic {
        EOR_DLY_IDLE = 1'h0,
        EOR_DLY_COUNT = 1'h1
    } eor_dly_state_t;

    typedef enum int {
        EOR_EV_RECORD_END = 0,
        EOR_EV_SAMPLES_FLOWING = 1,
        EOR_EV_WAVEFORM_TAG = 2
    } eor_event_t;
endpackage

`default_nettype wire

// ---- test/eor_event_output_router_monitor.sv ----
`default_nettype none

module eor_event_output_router_monitor #(
    parameter bit CHASSIS_VARIANT = 1'b1,
    parameter bit LVDS_CAPABLE = 1'b1,
    parameter int DELAY_W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // events and terminals
    input wire logic record_end_event,
    input wire logic samples_flowing_event,
    input wire logic waveform_tag_event,
    input wire logic [3:0] front_line,
    input wire logic [3:0] front_line_lvds,
    input wire logic [6:0] chassis_trigger_line,
    input wire logic [6:0] board_sync_line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] ev_d_r;
    logic rise_w;
    logic [6:0] ch_d_r;
    logic [6:0] ch_d2_r;
    logic ack_d_r;
    logic ch_step_w;

    // a departure from a held level; steps right after a bus write are config, not pulses
    assign ch_step_w = (chassis_trigger_line != ch_d_r) && (ch_d_r == ch_d2_r) && !ack_d_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ch_d_r <= 7'h0;
            ch_d2_r <= 7'h0;
            ack_d_r <= 1'b0;
        end else begin
            ch_d_r <= chassis_trigger_line;
            ch_d2_r <= ch_d_r;
            ack_d_r <= wb_ack_o;
        end
    end

    // only record end and tag may reach bus lines
    assign rise_w = (record_end_event & ~ev_d_r[0]) | (waveform_tag_event & ~ev_d_r[1]);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ev_d_r <= 2'h0;
        end else begin
            ev_d_r <= {waveform_tag_event, record_end_event};
        end
    end

    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without ack");
    chassis_width_a: assert property (ch_step_w |=> chassis_trigger_line == $past(ch_d_r))
        else $error("bus line pulse wider than one cycle");
    chassis_cause_a: assert property (ch_step_w |-> $past(rise_w, 2) || $past(rise_w, 3))
        else $error("bus line pulse without record end or tag event");
    sync_unused_a: assert property (CHASSIS_VARIANT |-> board_sync_line == 7'h0)
        else $error("sync line driven on chassis variant");
    lvds_hold_a: assert property (!wb_ack_o && !$past(wb_ack_o) |-> $stable(front_line_lvds))
        else $error("terminal mode moved without a bus write");
endmodule // eor_event_output_router_monitor

bind eor_event_output_router eor_event_output_router_monitor #(.CHASSIS_VARIANT(CHASSIS_VARIANT),
    .LVDS_CAPABLE(LVDS_CAPABLE), .DELAY_W(DELAY_W)) u_mon (.mclk(mclk), .rst_b(rst_b),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .record_end_event(record_end_event), .samples_flowing_event(samples_flowing_event),
    .waveform_tag_event(waveform_tag_event), .front_line(front_line), .front_line_lvds(front_line_lvds),
    .chassis_trigger_line(chassis_trigger_line), .board_sync_line(board_sync_line));

`default_nettype wire

// ---- test/eor_pulse_sink.sv ----
`default_nettype none

module eor_pulse_sink (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // terminals under watch
    input wire logic [3:0] front_line,
    input wire logic [6:0] chassis_trigger_line,
    input wire logic [6:0] board_sync_line,
    // one-cycle excursions seen, either polarity
    output logic [17:0] hit
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [17:0] now_w;
    logic [17:0] s1_r;
    logic [17:0] s2_r;

    assign now_w = {board_sync_line, chassis_trigger_line, front_line};
    // a level step is not a pulse; a pulse wider than one cycle goes unseen on purpose
    assign hit = (s1_r ^ s2_r) & (s1_r ^ now_w);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s1_r <= 18'h0;
            s2_r <= 18'h0;
        end else begin
            s1_r <= now_w;
            s2_r <= s1_r;
        end
    end
endmodule // eor_pulse_sink

`default_nettype wire

// ---- test/test_event_output_router.sv ----
`include "eor_defines.svh"
`default_nettype none

module test_event_output_router;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int cyc; logic [17:0] pat;} eor_exp_t;
    logic mclk, rst_b, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i, front_line, front_line_lvds;
    logic [2:0] ev;
    logic [6:0] chassis_trigger_line, board_sync_line;
    logic [17:0] hit;
    logic [7:0] lfsr;
    int err_total, checked, cyc_n, d;
    eor_exp_t eq[$];
    logic [31:0] rq[$];

    eor_event_output_router #(.CHASSIS_VARIANT(1'b1), .LVDS_CAPABLE(1'b1), .DELAY_W(8)) dut (.mclk(mclk),
        .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .record_end_event(ev[0]), .samples_flowing_event(ev[1]), .waveform_tag_event(ev[2]),
        .front_line(front_line), .front_line_lvds(front_line_lvds),
        .chassis_trigger_line(chassis_trigger_line), .board_sync_line(board_sync_line));
    eor_pulse_sink sink (.mclk(mclk), .rst_b(rst_b), .front_line(front_line),
        .chassis_trigger_line(chassis_trigger_line), .board_sync_line(board_sync_line), .hit(hit));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] cfg(input int dst, input logic [6:0] p, input logic [6:0] s,
        input logic [6:0] t);
        return {1'b0, t, 1'b0, s, 1'b0, p, 3'h0, dst[4:0]};
    endfunction

    // chassis variant: sync codes are not exported
    function automatic logic [17:0] bit_of(input int dst);
        return (dst >= 1 && dst <= 11) ? (18'h1 << (dst - 1)) : 18'h0;
    endfunction

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] dat);
        @(posedge mclk);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= dat;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        // only the watchdog ends a wait for ack
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        wb(a, 1'b1, dat);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask

    // pulse lands four edges after the event is raised; delay mode adds the programmed delay plus one
    task automatic fire(input logic [2:0] m, input logic [17:0] pat, input int extra);
        @(posedge mclk);
        ev <= m;
        if (pat !== 18'h0) eq.push_back('{cyc_n + 4 + extra, pat});
        @(posedge mclk);
        ev <= 3'h0;
        repeat (8 + extra) @(posedge mclk);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchers
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin : mon_b
        eor_exp_t e;
        cyc_n <= cyc_n + 1;
        if (rst_b === 1'b1 && hit !== 18'h0) begin
            if (eq.size() == 0) begin
                err_total++;
                $display("Error pulse expected none seen %h", hit);
            end else begin
                e = eq.pop_front();
                chk("pulse lines", {14'h0, e.pat}, {14'h0, hit});
                chk("pulse cycle", e.cyc, cyc_n);
            end
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (rq.size() == 0) begin
                err_total++;
                $display("Error read expected none seen %h", wb_dat_o);
            end else begin
                chk("read data", rq.pop_front(), wb_dat_o);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        wb_adr_i = 8'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        ev = 3'h0;
        lfsr = 8'h27;
        cyc_n = 0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rd(`EOR_OFS_CTRL, `EOR_RST_CTRL);
        rd(`EOR_OFS_CFG_WAVEFORM_TAG, `EOR_RST_CFG);
        rd(`EOR_OFS_DELAY, `EOR_RST_DELAY);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'h0);
        wr(`EOR_OFS_STATUS, 32'hffff_ffff);
        rd(`EOR_OFS_STATUS, 32'h0300_0000);
        for (d = 0; d < 19; d++) begin
            wr(`EOR_OFS_CFG_RECORD_END, cfg(d, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
            fire(3'b001, bit_of(d), 0);
        end
        wr(`EOR_OFS_CFG_RECORD_END, cfg(2, `EOR_POL_LOW, `EOR_POS_RISE, `EOR_TERM_SE));
        repeat (3) @(posedge mclk);
        chk("idle level", 32'h2, {28'h0, front_line});
        fire(3'b001, 18'h2, 0);
        wr(`EOR_OFS_CFG_RECORD_END, cfg(0, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
        wr(`EOR_OFS_CFG_SAMPLES_FLOWING, cfg(3, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
        fire(3'b010, 18'h0, 0);
        wr(`EOR_OFS_CTRL, 32'h1);
        fire(3'b010, 18'h4, 0);
        wr(`EOR_OFS_CFG_SAMPLES_FLOWING, cfg(3, `EOR_POL_HIGH, `EOR_POS_FALL, `EOR_TERM_SE));
        fire(3'b010, 18'h4, 0);
        wr(`EOR_OFS_DELAY, 32'h3);
        wr(`EOR_OFS_CFG_SAMPLES_FLOWING, cfg(3, `EOR_POL_HIGH, `EOR_POS_DELAY, `EOR_TERM_SE));
        fire(3'b010, 18'h4, 4);
        wr(`EOR_OFS_CFG_SAMPLES_FLOWING, cfg(5, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
        fire(3'b010, 18'h0, 0);
        wr(`EOR_OFS_CFG_WAVEFORM_TAG, cfg(1, `EOR_POL_LOW, `EOR_POS_RISE, `EOR_TERM_LVDS));
        repeat (3) @(posedge mclk);
        chk("tag idle gen", 32'h1, {28'h0, front_line});
        chk("lvds front", 32'h1, {28'h0, front_line_lvds});
        wr(`EOR_OFS_CTRL, 32'h0);
        wr(`EOR_OFS_CFG_RECORD_END, cfg(5, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
        repeat (3) @(posedge mclk);
        chk("tag idle off", 32'h0, {28'h0, front_line});
        fire(3'b101, 18'h11, 0);
        wr(`EOR_OFS_CFG_RECORD_END, cfg(0, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
        wr(`EOR_OFS_CFG_WAVEFORM_TAG, cfg(6, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_LVDS));
        repeat (3) @(posedge mclk);
        chk("lvds bus dest", 32'h0, {28'h0, front_line_lvds});
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            d = int'(lfsr % 8'd19);
            wr(`EOR_OFS_CFG_WAVEFORM_TAG, cfg(d, `EOR_POL_HIGH, `EOR_POS_RISE, `EOR_TERM_SE));
            fire(3'b100, bit_of(d), 0);
        end
        chk("leftover notes", 32'h0, eq.size() + rq.size());
        print_verdict();
    end
endmodule // test_event_output_router

`default_nettype wire
